// ===== hw/pasm_addr_gen.sv
/*
  pasm_addr_gen: forms the 24-bit program address for one request and registers it.
  assumes: req_src is one-hot whenever req_valid is high.
*/
`timescale 1ns/1ns
module pasm_addr_gen (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic req_valid,
  input wire pasm_pkg::pasm_src_t req_src,
  input wire logic [pasm_pkg::PC_W-1:0] pc,
  input wire logic [pasm_pkg::PAGE_W-1:0] tbl_page,
  input wire logic [pasm_pkg::PAGE_W-1:0] remap_page,
  input wire logic [pasm_pkg::EA_W-1:0] ea,
  output logic mem_req_q,
  output logic [pasm_pkg::ADDR_W-1:0] mem_addr_q,
  output logic upper_q,
  output logic vec_q,
  output logic id_q,
  output pasm_pkg::pasm_src_t src_q
);
  logic mem_req_d;
  logic [pasm_pkg::ADDR_W-1:0] mem_addr_d;
  logic upper_d;
  logic vec_d;
  logic id_d;
  pasm_pkg::pasm_src_t src_d;

  // ----------------------------------------
  // address forming
  // ----------------------------------------
  always_comb begin
    mem_req_d = req_valid;
    src_d = req_src;
    upper_d = 1'b0;
    mem_addr_d = {1'b0, pc}; // see RULE_02
    unique case (req_src)
      pasm_pkg::PASM_SRC_FETCH: begin
        mem_addr_d = {1'b0, pc[pasm_pkg::PC_W-1:1], 1'b0}; // see RULE_06
      end
      pasm_pkg::PASM_SRC_TABLE: begin
        mem_addr_d = {tbl_page, ea[pasm_pkg::EA_W-1:1], 1'b0}; // see RULE_10
        upper_d = ea[0]; // see RULE_05
      end
      pasm_pkg::PASM_SRC_REMAP: begin
        // ea[15] is dropped and bit 23 held low, so the page can never leave user space
        mem_addr_d = {1'b0, remap_page, ea[pasm_pkg::EA_W-2:1], 1'b0}; // see RULE_01
        upper_d = ea[0]; // see RULE_05
      end
      default: begin
        mem_req_d = 1'b0;
      end
    endcase
    // top half only reachable by a table read with the id page bit set
    if (mem_addr_d[pasm_pkg::ADDR_W-1] && !(req_src == pasm_pkg::PASM_SRC_TABLE)) begin
      mem_req_d = 1'b0; // see RULE_03
    end
    id_d = mem_req_d && mem_addr_d[pasm_pkg::ADDR_W-1]; // see RULE_04
    vec_d = mem_req_d && (mem_addr_d < pasm_pkg::VECTOR_END); // see RULE_07
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_req_q <= 1'b0;
      mem_addr_q <= 24'h000000;
      upper_q <= 1'b0;
      vec_q <= 1'b0;
      id_q <= 1'b0;
      src_q <= pasm_pkg::PASM_SRC_FETCH;
    end else begin
      mem_req_q <= mem_req_d;
      mem_addr_q <= mem_addr_d;
      upper_q <= upper_d;
      vec_q <= vec_d;
      id_q <= id_d;
      src_q <= src_d;
    end
  end
endmodule : pasm_addr_gen

// ===== hw/pasm_pc.sv
/*
  pasm_pc: the 23-bit program counter.
  assumes: the core gives at most one of advance, back or load per cycle; load wins.
*/
`timescale 1ns/1ns
module pasm_pc (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pc_advance,
  input wire logic pc_back,
  input wire logic pc_load,
  input wire logic [pasm_pkg::PC_W-1:0] pc_load_val,
  output logic [pasm_pkg::PC_W-1:0] pc_q
);
  logic [pasm_pkg::PC_W-1:0] pc_d;

  // ----------------------------------------
  // next value
  // ----------------------------------------
  always_comb begin
    pc_d = pc_q;
    if (pc_load) begin
      pc_d = {pc_load_val[pasm_pkg::PC_W-1:1], 1'b0}; // see RULE_06
    end else if (pc_advance) begin
      pc_d = pc_q + pasm_pkg::PC_STEP; // see RULE_06
    end else if (pc_back) begin
      pc_d = pc_q - pasm_pkg::PC_STEP; // see RULE_06
    end
  end

  // reset lands on the jump word at the bottom of the vector area
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_q <= pasm_pkg::PC_RESET; // see RULE_08
    end else begin
      pc_q <= pc_d;
    end
  end
endmodule : pasm_pc

// ===== hw/pasm_pkg.sv
/*
  pasm_pkg: constants shared by the program address space map.
  assumes: byte-addressed apb with 32-bit data, one aligned word per register.
*/
package pasm_pkg;
  // ----------------------------------------
  // address widths
  // ----------------------------------------
  localparam int ADDR_W = 24;
  localparam int PC_W = 23;
  localparam int PAGE_W = 8;
  localparam int EA_W = 16;
  localparam logic [PC_W-1:0] PC_STEP = 23'h000002;
  localparam logic [PC_W-1:0] PC_RESET = 23'h000000;
  localparam logic [ADDR_W-1:0] USER_TOP = 24'h7fffff;
  localparam logic [ADDR_W-1:0] VECTOR_END = 24'h000200;
  localparam int ID_PAGE_BIT = 7;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [11:0] TBL_PAGE_OFF = 12'h054;
  localparam logic [11:0] REMAP_PAGE_OFF = 12'h060;
  localparam logic [11:0] STATUS_OFF = 12'h064;
  localparam logic [11:0] PC_VIEW_OFF = 12'h068;
  localparam logic [11:0] LAST_ADDR_OFF = 12'h06c;
  localparam logic [15:0] TBL_PAGE_RST = 16'h0000;
  localparam logic [7:0] REMAP_PAGE_RST = 8'h00;
  localparam int STS_ID_READ = 0;
  localparam int STS_VEC_FETCH = 1;
  // ----------------------------------------
  // access sources
  // ----------------------------------------
  typedef enum logic [2:0] {
    PASM_SRC_FETCH = 3'b001,
    PASM_SRC_TABLE = 3'b010,
    PASM_SRC_REMAP = 3'b100
  } pasm_src_t;
endpackage : pasm_pkg

// ===== hw/pasm_top.sv
/*
  pasm_top: program address space map with its apb register file.
  assumes: the program memory answers mem_rdata combinationally in the cycle of mem_req;
  the core side holds its request inputs valid only in the cycle of req_valid.
*/
// Design decision made here: register access over APB.
`timescale 1ns/1ns
// What this block does
// RULE_01: program and data spaces on separate buses
// RULE_02: program addresses are 24 bits, three sources
// RULE_03: user access stays below 0x800000
// RULE_04: table read with page bit 7 reaches id
// RULE_05: odd upper word, its top byte reads zero
// RULE_06: counter stays even, steps by two
// RULE_07: addresses below 0x000200 are the vector table
// RULE_08: software puts the reset jump at address zero
// RULE_09: page register at 0x54, eight bits, reset zero
// RULE_10: table address is page over effective address
module pasm_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pc_advance,
  input wire logic pc_back,
  input wire logic pc_load,
  input wire logic [pasm_pkg::PC_W-1:0] pc_load_val,
  output logic [pasm_pkg::PC_W-1:0] pc,
  input wire logic req_valid,
  input wire pasm_pkg::pasm_src_t req_src,
  input wire logic [pasm_pkg::EA_W-1:0] req_ea,
  output logic mem_req,
  output logic [pasm_pkg::ADDR_W-1:0] mem_addr,
  input wire logic [pasm_pkg::ADDR_W-1:0] mem_rdata,
  output logic rsp_valid,
  output logic [pasm_pkg::ADDR_W-1:0] rsp_data,
  output logic rsp_vector
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic [pasm_pkg::PAGE_W-1:0] tbl_page_q, tbl_page_d;
  logic [pasm_pkg::PAGE_W-1:0] remap_page_q, remap_page_d;
  logic [1:0] status_q, status_d;
  logic [pasm_pkg::ADDR_W-1:0] last_addr_q, last_addr_d;
  logic [31:0] prdata_q, prdata_d;
  logic rsp_valid_q, rsp_valid_d;
  logic [pasm_pkg::ADDR_W-1:0] rsp_data_q, rsp_data_d;
  logic rsp_vector_q, rsp_vector_d;
  logic mem_req_q, upper_q, vec_q, id_q;
  logic [pasm_pkg::ADDR_W-1:0] mem_addr_q;
  pasm_pkg::pasm_src_t src_q;
  logic setup, wr_access, mapped;

  // ----------------------------------------
  // program counter and address forming
  // ----------------------------------------
  pasm_pc u_pc (
    .pclk(pclk),
    .presetn(presetn),
    .pc_advance(pc_advance),
    .pc_back(pc_back),
    .pc_load(pc_load),
    .pc_load_val(pc_load_val),
    .pc_q(pc)
  );

  pasm_addr_gen u_addr (
    .pclk(pclk),
    .presetn(presetn),
    .req_valid(req_valid),
    .req_src(req_src),
    .pc(pc),
    .tbl_page(tbl_page_q),
    .remap_page(remap_page_q),
    .ea(req_ea),
    .mem_req_q(mem_req_q),
    .mem_addr_q(mem_addr_q),
    .upper_q(upper_q),
    .vec_q(vec_q),
    .id_q(id_q),
    .src_q(src_q)
  );

  // program memory sits on its own bus, never on apb
  assign mem_req = mem_req_q; // see RULE_01
  assign mem_addr = mem_addr_q;

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  // zero wait states: read data is sampled in the setup cycle
  assign setup = psel && !penable;
  assign wr_access = psel && penable && pwrite && mapped;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_q;

  always_comb begin
    mapped = (paddr == pasm_pkg::TBL_PAGE_OFF) || (paddr == pasm_pkg::REMAP_PAGE_OFF) ||
             (paddr == pasm_pkg::STATUS_OFF) || (paddr == pasm_pkg::PC_VIEW_OFF) ||
             (paddr == pasm_pkg::LAST_ADDR_OFF);
    prdata_d = prdata_q;
    if (setup) begin
      prdata_d = 32'h00000000;
      unique case (paddr)
        pasm_pkg::TBL_PAGE_OFF: prdata_d = {24'h000000, tbl_page_q}; // see RULE_09
        pasm_pkg::REMAP_PAGE_OFF: prdata_d = {24'h000000, remap_page_q};
        pasm_pkg::STATUS_OFF: prdata_d = {30'h0, status_q};
        pasm_pkg::PC_VIEW_OFF: prdata_d = {9'h0, pc};
        pasm_pkg::LAST_ADDR_OFF: prdata_d = {8'h00, last_addr_q};
        default: prdata_d = 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_comb begin
    tbl_page_d = tbl_page_q;
    remap_page_d = remap_page_q;
    status_d = status_q;
    last_addr_d = last_addr_q;
    if (wr_access && paddr == pasm_pkg::TBL_PAGE_OFF) begin
      tbl_page_d = pwdata[pasm_pkg::PAGE_W-1:0]; // see RULE_09
    end
    if (wr_access && paddr == pasm_pkg::REMAP_PAGE_OFF) begin
      remap_page_d = pwdata[pasm_pkg::PAGE_W-1:0];
    end
    if (wr_access && paddr == pasm_pkg::STATUS_OFF) begin
      status_d = status_q & ~pwdata[1:0];
    end
    // set after clear so a same-cycle event is kept
    if (id_q) begin
      status_d[pasm_pkg::STS_ID_READ] = 1'b1; // see RULE_04
    end
    if (vec_q && src_q == pasm_pkg::PASM_SRC_FETCH) begin
      status_d[pasm_pkg::STS_VEC_FETCH] = 1'b1; // see RULE_07
    end
    if (mem_req_q) begin
      last_addr_d = mem_addr_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tbl_page_q <= pasm_pkg::TBL_PAGE_RST[pasm_pkg::PAGE_W-1:0]; // see RULE_09
      remap_page_q <= pasm_pkg::REMAP_PAGE_RST;
      status_q <= 2'h0;
      last_addr_q <= 24'h000000;
      prdata_q <= 32'h00000000;
    end else begin
      tbl_page_q <= tbl_page_d;
      remap_page_q <= remap_page_d;
      status_q <= status_d;
      last_addr_q <= last_addr_d;
      prdata_q <= prdata_d;
    end
  end

  // ----------------------------------------
  // answer to the core
  // ----------------------------------------
  always_comb begin
    rsp_valid_d = mem_req_q;
    rsp_vector_d = vec_q;
    rsp_data_d = 24'h000000;
    if (mem_req_q) begin
      if (src_q == pasm_pkg::PASM_SRC_FETCH) begin
        rsp_data_d = mem_rdata; // see RULE_02
      end else if (upper_q) begin
        // upper byte of the upper word is not built
        rsp_data_d = {16'h0000, mem_rdata[23:16]}; // see RULE_05
      end else begin
        rsp_data_d = {8'h00, mem_rdata[15:0]}; // see RULE_05
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp_valid_q <= 1'b0;
      rsp_data_q <= 24'h000000;
      rsp_vector_q <= 1'b0;
    end else begin
      rsp_valid_q <= rsp_valid_d;
      rsp_data_q <= rsp_data_d;
      rsp_vector_q <= rsp_vector_d;
    end
  end

  assign rsp_valid = rsp_valid_q;
  assign rsp_data = rsp_data_q;
  assign rsp_vector = rsp_vector_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_PC_EVEN: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_06
    pc[0] == 1'b0) else $error("program counter left the lower word");

  AST_PC_STEP: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_06
    (pc_advance && !pc_load) |=> pc == $past(pc) + pasm_pkg::PC_STEP)
    else $error("program counter did not advance by two");

  AST_USER_HALF: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_03
    (mem_req && src_q != pasm_pkg::PASM_SRC_TABLE) |-> mem_addr <= pasm_pkg::USER_TOP)
    else $error("access outside the user half");

  AST_ID_READ: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_04
    (req_valid && req_src == pasm_pkg::PASM_SRC_TABLE && tbl_page_q[pasm_pkg::ID_PAGE_BIT])
    |=> mem_req && mem_addr[23] ##1 status_q[pasm_pkg::STS_ID_READ])
    else $error("id section read not passed or not flagged");

  AST_TABLE_ADDR: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_10
    (req_valid && req_src == pasm_pkg::PASM_SRC_TABLE)
    |=> mem_addr == {$past(tbl_page_q), $past(req_ea[15:1]), 1'b0})
    else $error("table address not page over effective address");

  AST_REMAP_ADDR: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_01
    (req_valid && req_src == pasm_pkg::PASM_SRC_REMAP)
    |=> mem_req && mem_addr[23:15] == {1'b0, $past(remap_page_q)})
    else $error("remapped read went to the wrong page");

  AST_RSP_TIME: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_02
    req_valid |=> mem_req ##1 rsp_valid)
    else $error("answer not two edges after request");

  AST_UPPER_ZERO: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_05
    (mem_req && upper_q && src_q != pasm_pkg::PASM_SRC_FETCH) |=> rsp_data[23:8] == 16'h0000)
    else $error("upper word top byte not zero");

  AST_VECTOR: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_07
    (mem_req && mem_addr < pasm_pkg::VECTOR_END) |=> rsp_vector)
    else $error("vector area access not marked");

  AST_PAGE_REG: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_09
    (setup && !pwrite && paddr == pasm_pkg::TBL_PAGE_OFF) |=> prdata[31:8] == 24'h000000
    && prdata[7:0] == tbl_page_q) else $error("page register read wrong");

  // ----------------------------------------
  // checks on counter, addresses, flags, page register and answer data
  // ----------------------------------------
  AST_PC_BACK: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_06
    (pc_back && !pc_advance && !pc_load) |=> pc == $past(pc) - pasm_pkg::PC_STEP)
    else $error("program counter did not step back by two");

  AST_PC_LOAD: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_06
    pc_load |=> pc == {$past(pc_load_val[pasm_pkg::PC_W-1:1]), 1'b0})
    else $error("loaded program counter not on the lower word");

  AST_FETCH_ADDR: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_02
    (req_valid && req_src == pasm_pkg::PASM_SRC_FETCH) |=> mem_req && mem_addr == {1'b0, $past(pc)})
    else $error("fetch address not taken from the program counter");

  AST_IDLE_NO_REQ: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_02
    !req_valid |=> !mem_req)
    else $error("memory strobe without a request");

  AST_UPPER_SEL: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_05
    (req_valid && (req_src == pasm_pkg::PASM_SRC_TABLE || req_src == pasm_pkg::PASM_SRC_REMAP))
    |=> upper_q == $past(req_ea[0])) else $error("word select not from address bit zero");

  AST_ID_ONLY_TABLE: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_04
    (mem_req && mem_addr[pasm_pkg::ADDR_W-1]) |-> src_q == pasm_pkg::PASM_SRC_TABLE)
    else $error("upper half reached by a non-table access");

  AST_VEC_ONLY_LOW: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_07
    (mem_req && mem_addr >= pasm_pkg::VECTOR_END) |=> !rsp_vector)
    else $error("vector mark outside the vector area");

  AST_STS_CLEAR: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_04
    (wr_access && paddr == pasm_pkg::STATUS_OFF && pwdata[pasm_pkg::STS_ID_READ] && !id_q)
    |=> !status_q[pasm_pkg::STS_ID_READ]) else $error("id read flag not cleared");

  AST_VEC_FLAG: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_07
    (vec_q && src_q == pasm_pkg::PASM_SRC_FETCH) |=> status_q[pasm_pkg::STS_VEC_FETCH])
    else $error("vector fetch not flagged");

  AST_PAGE_WRITE: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_09
    (wr_access && paddr == pasm_pkg::TBL_PAGE_OFF) |=> tbl_page_q == $past(pwdata[pasm_pkg::PAGE_W-1:0]))
    else $error("page register write lost");

  AST_PAGE_HOLD: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_09
    !(wr_access && paddr == pasm_pkg::TBL_PAGE_OFF) |=> $stable(tbl_page_q))
    else $error("page register changed without a write");

  AST_RSP_FETCH: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_02
    (mem_req && src_q == pasm_pkg::PASM_SRC_FETCH) |=> rsp_data == $past(mem_rdata))
    else $error("fetch answer not the full location");

  AST_LOWER_WORD: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_05
    (mem_req && !upper_q && src_q != pasm_pkg::PASM_SRC_FETCH) |=> rsp_data == {8'h00, $past(mem_rdata[15:0])})
    else $error("lower word answer wrong");

  COV_ID_READ: cover property (@(posedge pclk) disable iff (!presetn) mem_req && id_q);
  COV_REMAP: cover property (@(posedge pclk) disable iff (!presetn)
    rsp_valid && src_q == pasm_pkg::PASM_SRC_REMAP);
  COV_RESET_FETCH: cover property (@(posedge pclk) disable iff (!presetn) rsp_valid && rsp_vector);
  COV_PAGE_WRITE: cover property (@(posedge pclk) disable iff (!presetn)
    wr_access && paddr == pasm_pkg::TBL_PAGE_OFF);
  COV_PC_BACK: cover property (@(posedge pclk) disable iff (!presetn) pc_back && !pc_load);
endmodule : pasm_top

// ===== verification/pasm_mem_model.sv
/*
  pasm_mem_model: behavioural program memory on the far side of the map.
  assumes: mem_addr is stable while mem_req is high; answers in the same cycle.
*/
`timescale 1ns/1ns
module pasm_mem_model #(
  parameter logic [23:0] JUMP_WORD = 24'h04c0de,
  parameter logic [23:0] START_ADDR = 24'h000400
) (
  input wire logic mem_req,
  input wire logic [23:0] mem_addr,
  output logic [23:0] mem_rdata
);
  // ----------------------------------------
  // content
  // ----------------------------------------
  function automatic logic [23:0] word(input logic [23:0] a);
    if (a == 24'h000000) return JUMP_WORD;
    if (a == 24'h000002) return START_ADDR;
    return a ^ 24'ha5c3e1;
  endfunction : word
  // not requested: show the inverse, so a stale sample never looks right
  assign mem_rdata = mem_req ? word(mem_addr) : ~word(mem_addr);
endmodule : pasm_mem_model

// ===== verification/pasm_top_bench.sv
/*
  pasm_top_bench: self-checking bench of the program address space map.
  assumes: zero-wait apb and a fixed two-cycle core answer, as handed over.
*/
`timescale 1ns/1ns
module pasm_top_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic pc_advance, pc_back, pc_load, req_valid, mem_req, rsp_valid, rsp_vector, e;
  logic [22:0] pc_load_val, pc;
  pasm_pkg::pasm_src_t req_src;
  logic [15:0] req_ea;
  logic [23:0] mem_addr, mem_rdata, rsp_data, w;
  int n_mismatch = 0;
  int checks_done = 0;
  pasm_top i_pasm_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pc_advance(pc_advance), .pc_back(pc_back), .pc_load(pc_load),
    .pc_load_val(pc_load_val), .pc(pc), .req_valid(req_valid), .req_src(req_src),
    .req_ea(req_ea), .mem_req(mem_req), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_vector(rsp_vector));
  pasm_mem_model i_pasm_mem_model (.mem_req(mem_req), .mem_addr(mem_addr), .mem_rdata(mem_rdata));
  // ----------------------------------------
  // clock, reset, watchdog
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial begin
    #200000;
    n_mismatch++;
    print_verdict();
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic print_verdict();
    if (n_mismatch == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_word
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_word({31'h0, got}, {31'h0, exp});
  endtask : cmp_bit
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic pc_cmd(input logic adv, input logic bk, input logic ld, input logic [22:0] v);
    @(posedge pclk);
    pc_advance <= adv;
    pc_back <= bk;
    pc_load <= ld;
    pc_load_val <= v;
    @(posedge pclk);
    pc_advance <= 1'b0;
    pc_back <= 1'b0;
    pc_load <= 1'b0;
    #1;
  endtask : pc_cmd
  // one request, then the memory strobe one edge later and the answer one edge after that
  task automatic core_req(input pasm_pkg::pasm_src_t s, input logic [15:0] ea,
                          input logic [23:0] a_exp, input logic [1:0] kind, input logic v_exp);
    @(posedge pclk);
    req_valid <= 1'b1;
    req_src <= s;
    req_ea <= ea;
    @(posedge pclk);
    req_valid <= 1'b0;
    #1;
    cmp_bit(mem_req, 1'b1);
    cmp_word({8'h00, mem_addr}, {8'h00, a_exp});
    w = i_pasm_mem_model.word(a_exp);
    @(posedge pclk);
    #1;
    cmp_bit(rsp_valid, 1'b1);
    cmp_bit(rsp_vector, v_exp);
    if (kind == 2'd0) cmp_word({8'h00, rsp_data}, {8'h00, w});
    else if (kind == 2'd1) cmp_word({8'h00, rsp_data}, {16'h0000, w[15:0]});
    else cmp_word({8'h00, rsp_data}, {24'h000000, w[23:16]});
  endtask : core_req
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic test_regs();
    apb(1'b0, 12'h054, 32'h0);
    cmp_word(r, 32'h00000000);
    cmp_bit(e, 1'b0);
    apb(1'b1, 12'h054, 32'hffffffff);
    apb(1'b0, 12'h054, 32'h0);
    cmp_word(r, 32'h000000ff);
    apb(1'b0, 12'h100, 32'h0);
    cmp_bit(e, 1'b1);
    cmp_word(r, 32'h00000000);
  endtask : test_regs
  task automatic test_pc();
    cmp_word({9'h0, pc}, 32'h0);
    pc_cmd(1'b1, 1'b0, 1'b0, 23'h0);
    pc_cmd(1'b1, 1'b0, 1'b0, 23'h0);
    cmp_word({9'h0, pc}, 32'h4);
    pc_cmd(1'b0, 1'b1, 1'b0, 23'h0);
    cmp_word({9'h0, pc}, 32'h2);
    pc_cmd(1'b0, 1'b0, 1'b1, 23'h0001ff);
    cmp_word({9'h0, pc}, 32'h1fe);
  endtask : test_pc
  task automatic test_fetch();
    core_req(pasm_pkg::PASM_SRC_FETCH, 16'h0, 24'h0001fe, 2'd0, 1'b1);
    pc_cmd(1'b1, 1'b0, 1'b0, 23'h0);
    core_req(pasm_pkg::PASM_SRC_FETCH, 16'h0, 24'h000200, 2'd0, 1'b0);
    pc_cmd(1'b0, 1'b0, 1'b1, 23'h0);
    core_req(pasm_pkg::PASM_SRC_FETCH, 16'h0, 24'h000000, 2'd0, 1'b1);
    pc_cmd(1'b1, 1'b0, 1'b0, 23'h0);
    core_req(pasm_pkg::PASM_SRC_FETCH, 16'h0, 24'h000002, 2'd0, 1'b1);
  endtask : test_fetch
  task automatic test_table();
    apb(1'b1, 12'h054, 32'h00000080);
    core_req(pasm_pkg::PASM_SRC_TABLE, 16'h0003, 24'h800002, 2'd2, 1'b0);
    core_req(pasm_pkg::PASM_SRC_TABLE, 16'h1234, 24'h801234, 2'd1, 1'b0);
    apb(1'b0, 12'h064, 32'h0);
    cmp_word(r, 32'h00000003);
    apb(1'b1, 12'h064, 32'h00000003);
    apb(1'b0, 12'h064, 32'h0);
    cmp_word(r, 32'h00000000);
  endtask : test_table
  task automatic test_remap();
    apb(1'b1, 12'h060, 32'h000000ff);
    core_req(pasm_pkg::PASM_SRC_REMAP, 16'hffff, 24'h7ffffe, 2'd2, 1'b0);
    core_req(pasm_pkg::PASM_SRC_REMAP, 16'h0002, 24'h7f8002, 2'd1, 1'b0);
    apb(1'b0, 12'h06c, 32'h0);
    cmp_word(r, 32'h007f8002);
    apb(1'b0, 12'h068, 32'h0);
    cmp_word(r, 32'h00000002);
  endtask : test_remap
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pc_advance = 1'b0;
    pc_back = 1'b0;
    pc_load = 1'b0;
    pc_load_val = 23'h0;
    req_valid = 1'b0;
    req_src = pasm_pkg::PASM_SRC_FETCH;
    req_ea = 16'h0000;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    test_regs();
    test_pc();
    test_fetch();
    test_table();
    test_remap();
    print_verdict();
  end
endmodule : pasm_top_bench
